// file: shared/lsp_pkg.sv
// package for the line synchronization protection monitor
// assumes measurements arrive as unsigned scaled integers on core_clk
package lsp_pkg;
    // fault numbers as reported on the fault code port
    localparam logic [7:0] LSP_CODE_NONE   = 8'h00;
    localparam logic [7:0] LSP_CODE_BOTH   = 8'h50; // 80
    localparam logic [7:0] LSP_CODE_CAN    = 8'h51; // 81
    localparam logic [7:0] LSP_CODE_FREQ   = 8'h52; // 82
    localparam logic [7:0] LSP_CODE_VOLT   = 8'h53; // 83
    localparam logic [7:0] LSP_CODE_CURR   = 8'h54; // 84
    localparam logic [7:0] LSP_CODE_DCLOW  = 8'h55; // 85
    localparam logic [7:0] LSP_CODE_ACLOW  = 8'h56; // 86
    localparam logic [7:0] LSP_CODE_BYPASS = 8'h57; // 87
    // fault bit positions in the latched fault vector
    localparam int LSP_F_BOTH   = 0;
    localparam int LSP_F_CAN    = 1;
    localparam int LSP_F_FREQ   = 2;
    localparam int LSP_F_VOLT   = 3;
    localparam int LSP_F_CURR   = 4;
    localparam int LSP_F_DCLOW  = 5;
    localparam int LSP_F_ACLOW  = 6;
    localparam int LSP_F_BYPASS = 7;
    localparam int LSP_NFAULT   = 8;
    // line frequency window in 0.01 Hz units (exclusive bounds)
    localparam logic [15:0] LSP_FREQ_MIN = 16'h09C4; // 25.00 Hz
    localparam logic [15:0] LSP_FREQ_MAX = 16'h1D4C; // 75.00 Hz
    // percentage thresholds
    localparam logic [7:0] LSP_VOLT_PCT = 8'h5A; // 90 %
    localparam logic [7:0] LSP_CURR_PCT = 8'h0F; // 15 %
    localparam logic [7:0] LSP_PCT_FULL = 8'h64; // 100 %
    // dc-low response selections
    typedef enum logic [1:0] {
        LSP_RESP_NONE  = 2'b00,
        LSP_RESP_WARN  = 2'b01,
        LSP_RESP_FAULT = 2'b10
    } lsp_resp_t;
endpackage

// file: hw/lsp_monitor.sv
// line synchronization protection monitor: latches faults 80..87,
// forces contactors open and gates the changeover to the mains
// assumes measurements and commands are synchronous to core_clk;
// interlock and stop inputs are pins and are synchronised here
`timescale 1ns/1ps
`default_nettype none
module lsp_monitor
    import lsp_pkg::*;
#(
    parameter int NCONT = 4 // number of contactor outputs
) (
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic              modulating,
    input  wire logic              fb_in_use,
    input  wire logic              fb_converter_side_closed,
    input  wire logic              fb_net_closed,
    input  wire logic              can_link_ok,
    input  wire logic [15:0]       line_freq,
    input  wire logic [15:0]       line_volt,
    input  wire logic [15:0]       motor_nom_volt,
    input  wire logic [15:0]       motor_current,
    input  wire logic [15:0]       motor_nom_current,
    input  wire logic              converter_side_ctrl,
    input  wire logic [15:0]       dc_volt,
    input  wire logic [15:0]       dc_low_limit,
    input  wire logic [1:0]        dc_low_resp,
    input  wire logic [15:0]       line_rms,
    input  wire logic [15:0]       line_rms_limit,
    input  wire logic              interlock_ok_pin,
    input  wire logic              estop_pin,
    input  wire logic              safety_pin,
    input  wire logic [NCONT-1:0]  contactor_cmd,
    input  wire logic              sync_req,
    input  wire logic              fault_reset,
    output logic [NCONT-1:0]       contactor_out,
    output logic                   stop_modulation,
    output logic                   sync_permit,
    output logic                   changeover_permit,
    output logic [LSP_NFAULT-1:0]  faults,
    output logic                   dc_low_warning,
    output logic [7:0]             fault_code
);
    // elaboration check: contactor word must exist and fit a byte
    if (NCONT < 1 || NCONT > 8) begin : g_bad_ncont
        $error("lsp_monitor: NCONT must be 1..8");
    end

    // percentage compare: value*100 < ref*pct, 24 bits keep products exact
    function automatic logic below_pct(input logic [15:0] val,
                                       input logic [15:0] nom,
                                       input logic [7:0]  pct);
        logic [23:0] lhs;
        logic [23:0] rhs;
        lhs = 24'(val) * 24'(LSP_PCT_FULL);
        rhs = 24'(nom) * 24'(pct);
        return lhs < rhs;
    endfunction

    // all module state in one record
    typedef struct packed {
        logic [2:0]            ilk_sync;   // interlock synchroniser
        logic [2:0]            estop_sync; // emergency stop synchroniser
        logic [2:0]            safe_sync;  // safety input synchroniser
        logic                  ilk_ok;     // filtered interlock level
        logic                  estop;      // filtered stop level
        logic                  safe;       // filtered safety level
        logic [LSP_NFAULT-1:0] flt;        // latched faults
        logic                  warn;       // dc-low warning, self clearing
        logic [NCONT-1:0]      cout;       // contactor outputs
        logic                  stop;       // stop modulation
        logic                  sperm;      // sync permitted
        logic                  cperm;      // changeover permitted
        logic [7:0]            code;       // lowest active fault number
    } lsp_state_t;

    lsp_state_t st_r;   // registered state
    lsp_state_t st_nxt; // next state

    // live conditions, evaluated from current inputs
    logic cond_both;  // contactors both closed while running
    logic cond_freq;  // frequency outside window
    logic cond_volt;  // line voltage under 90 %
    logic cond_curr;  // current under 15 % while converter side
    logic cond_dc;    // dc-link under limit
    logic cond_ac;    // line rms under limit
    logic word_zero;  // no online contactor commanded
    logic force_open; // any reason to drop every contactor

    always_comb begin
        cond_both = fb_in_use && modulating && fb_converter_side_closed && fb_net_closed;
        cond_freq = !(line_freq > LSP_FREQ_MIN && line_freq < LSP_FREQ_MAX);
        cond_volt = below_pct(line_volt, motor_nom_volt, LSP_VOLT_PCT);
        cond_curr = converter_side_ctrl && below_pct(motor_current, motor_nom_current, LSP_CURR_PCT);
        cond_dc   = dc_volt < dc_low_limit;
        cond_ac   = line_rms < line_rms_limit;
        word_zero = contactor_cmd == '0;
    end

    // next-state logic: set beats reset in the same cycle
    always_comb begin
        logic [LSP_NFAULT-1:0] set_v;
        logic [LSP_NFAULT-1:0] clr_v;
        set_v  = '0;
        clr_v  = '0;
        st_nxt = st_r;
        // three-stage synchronisers; only stages 2 and 3 are compared
        st_nxt.ilk_sync   = {st_r.ilk_sync[1:0], interlock_ok_pin};
        st_nxt.estop_sync = {st_r.estop_sync[1:0], estop_pin};
        st_nxt.safe_sync  = {st_r.safe_sync[1:0], safety_pin};
        if (st_r.ilk_sync[2] == st_r.ilk_sync[1]) begin
            st_nxt.ilk_ok = st_r.ilk_sync[2];
        end
        if (st_r.estop_sync[2] == st_r.estop_sync[1]) begin
            st_nxt.estop = st_r.estop_sync[2];
        end
        if (st_r.safe_sync[2] == st_r.safe_sync[1]) begin
            st_nxt.safe = st_r.safe_sync[2];
        end
        // fault sets
        set_v[LSP_F_BOTH]   = cond_both;
        set_v[LSP_F_CAN]    = !can_link_ok;
        set_v[LSP_F_FREQ]   = sync_req && cond_freq;
        set_v[LSP_F_VOLT]   = sync_req && cond_volt;
        set_v[LSP_F_CURR]   = sync_req && cond_curr;
        set_v[LSP_F_DCLOW]  = cond_dc && dc_low_resp == LSP_RESP_FAULT;
        set_v[LSP_F_ACLOW]  = cond_ac;
        set_v[LSP_F_BYPASS] = !st_r.ilk_ok;
        // clears; can loss is not cleared by fault_reset, only by sys_rst
        if (fault_reset) begin
            clr_v[LSP_F_BOTH]   = 1'b1;
            clr_v[LSP_F_FREQ]   = 1'b1;
            clr_v[LSP_F_VOLT]   = 1'b1;
            clr_v[LSP_F_CURR]   = 1'b1;
            clr_v[LSP_F_DCLOW]  = word_zero;
            clr_v[LSP_F_ACLOW]  = word_zero;
            clr_v[LSP_F_BYPASS] = word_zero;
        end
        st_nxt.flt  = set_v | (st_r.flt & ~clr_v);
        // warning follows the condition, so it clears by itself
        st_nxt.warn = cond_dc && dc_low_resp == LSP_RESP_WARN;
        // contactors drop for can loss, dc low, ac low, interlock, stops
        force_open = st_nxt.flt[LSP_F_CAN] || st_nxt.flt[LSP_F_DCLOW] || st_nxt.warn
                   || st_nxt.flt[LSP_F_ACLOW] || st_nxt.flt[LSP_F_BYPASS]
                   || st_r.estop || st_r.safe;
        st_nxt.cout  = force_open ? '0 : contactor_cmd;
        st_nxt.stop  = st_nxt.flt[LSP_F_BOTH];
        st_nxt.sperm = sync_req && !cond_freq && !cond_volt && st_nxt.flt == '0;
        st_nxt.cperm = st_nxt.sperm && !cond_curr;
        // report lowest numbered active fault
        st_nxt.code = LSP_CODE_NONE;
        for (int i = LSP_NFAULT - 1; i >= 0; i--) begin
            if (st_nxt.flt[i]) begin
                st_nxt.code = LSP_CODE_BOTH + 8'(i);
            end
        end
    end

    // register; interlock filter starts "ok" so reset does not raise 87
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_r          <= '0;
            st_r.ilk_sync <= 3'b111;
            st_r.ilk_ok   <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flip-flops
    assign contactor_out     = st_r.cout;
    assign stop_modulation   = st_r.stop;
    assign sync_permit       = st_r.sperm;
    assign changeover_permit = st_r.cperm;
    assign faults            = st_r.flt;
    assign dc_low_warning    = st_r.warn;
    assign fault_code        = st_r.code;

    // both-closed while running stops modulation next cycle
    a_both_stop: assert property (@(posedge core_clk) disable iff (sys_rst)
        cond_both |=> stop_modulation && faults[LSP_F_BOTH])
        else $error("both-closed did not stop modulation");
    // no both-closed fault without feedback in use
    a_both_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(faults[LSP_F_BOTH]) |-> $past(fb_in_use))
        else $error("both-closed fault without feedback in use");
    // can fault clears only on sys_rst and keeps contactors open
    a_can_latch: assert property (@(posedge core_clk) disable iff (sys_rst)
        faults[LSP_F_CAN] |=> faults[LSP_F_CAN] && contactor_out == '0)
        else $error("can fault cleared or contactors on");
    // out-of-window frequency never permits sync
    a_freq_win: assert property (@(posedge core_clk) disable iff (sys_rst)
        sync_req && cond_freq |=> !sync_permit && faults[LSP_F_FREQ])
        else $error("sync permitted outside frequency window");
    // low line voltage refuses sync
    a_volt_low: assert property (@(posedge core_clk) disable iff (sys_rst)
        sync_req && cond_volt |=> !sync_permit && faults[LSP_F_VOLT])
        else $error("sync permitted at low voltage");
    // low current refuses changeover
    a_curr_low: assert property (@(posedge core_clk) disable iff (sys_rst)
        sync_req && cond_curr |=> !changeover_permit && faults[LSP_F_CURR])
        else $error("changeover permitted at low current");
    // dc low with warning or fault response opens every contactor; code 3 acts as none
    a_dc_open: assert property (@(posedge core_clk) disable iff (sys_rst)
        cond_dc && (dc_low_resp == LSP_RESP_FAULT || dc_low_resp == LSP_RESP_WARN) |=> contactor_out == '0)
        else $error("dc low left contactors closed");
    // dc fault reset refused while any contactor commanded
    a_dc_reset: assert property (@(posedge core_clk) disable iff (sys_rst)
        faults[LSP_F_DCLOW] && !word_zero |=> faults[LSP_F_DCLOW])
        else $error("dc fault cleared with nonzero word");
    // no response setting never raises 85
    a_dc_none: assert property (@(posedge core_clk) disable iff (sys_rst)
        dc_low_resp == LSP_RESP_NONE && !faults[LSP_F_DCLOW] |=> !faults[LSP_F_DCLOW])
        else $error("dc fault raised with no response");
    // ac low opens contactors and holds until zero word reset
    a_ac_low: assert property (@(posedge core_clk) disable iff (sys_rst)
        cond_ac |=> faults[LSP_F_ACLOW] && contactor_out == '0)
        else $error("ac low not handled");
    // interlock loss reaches outputs within five cycles
    a_ilk_open: assert property (@(posedge core_clk) disable iff (sys_rst)
        !interlock_ok_pin [*4] |=> ##[0:2] contactor_out == '0)
        else $error("interlock loss left contactors closed");
    // stop inputs force open
    a_stop_open: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_r.estop || st_r.safe |=> contactor_out == '0)
        else $error("stop input left contactors closed");
    // a latched fault stays without reset
    a_latch_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        faults[LSP_F_FREQ] && !fault_reset |=> faults[LSP_F_FREQ])
        else $error("fault cleared without reset");

    c_sync_ok:   cover property (@(posedge core_clk) disable iff (sys_rst) changeover_permit);
    c_both:      cover property (@(posedge core_clk) disable iff (sys_rst) $rose(stop_modulation));
    c_dc_warn:   cover property (@(posedge core_clk) disable iff (sys_rst) $fell(dc_low_warning));
    c_ilk_clear: cover property (@(posedge core_clk) disable iff (sys_rst) $fell(faults[LSP_F_BYPASS]));
endmodule // lsp_monitor
`default_nettype wire

// file: bench/lsp_far_side.sv
// far-side model: motor contactors, line measurement board and can i/o
// assumes contactor_out bit 0 is the converter_side contactor and bit 1 the net one
`timescale 1ns/1ps
`default_nettype none
module lsp_far_side (
    input  wire logic       core_clk,
    input  wire logic [3:0] contactor_out,
    input  wire logic       weld,                     // net contactor stuck closed
    input  wire logic       can_fail,                 // can i/o stops answering
    input  wire logic       line_down,                // three-phase supply lost
    output logic            fb_converter_side_closed,
    output logic            fb_net_closed,
    output logic            can_link_ok,
    output logic            interlock_ok_pin
);
    // contactors report closed one cycle after the coil is driven, a weld keeps net closed
    always_ff @(posedge core_clk) begin
        fb_converter_side_closed <= contactor_out[0];
        fb_net_closed            <= contactor_out[1] | weld;
    end
    // link health and interlock follow the fault knobs, no self recovery
    assign can_link_ok      = ~can_fail;
    assign interlock_ok_pin = ~line_down;
endmodule // lsp_far_side
`default_nettype wire

// file: bench/line_sync_protection_monitor_test.sv
// self-checking bench of the line synchronization protection monitor
// assumes lsp_monitor with NCONT = 4 and the far-side model beside it
`timescale 1ns/1ps
`default_nettype none
module line_sync_protection_monitor_test;
    import lsp_pkg::*;
    typedef struct packed {
        logic [3:0]  kind;  // which input the row disturbs
        logic [15:0] val;   // value put on that input
        logic [7:0]  ef;    // faults expected afterwards
    } lsp_row_t;
    localparam int NROW = 17; // last row drives the spare response code, which acts as none
    // boundary pairs around the frequency, voltage and current thresholds, nominal values are 1000 and limits 500
    localparam lsp_row_t ROWS [NROW] = '{'{4'h0, 16'h0000, 8'h00},
        '{4'h1, 16'h09C4, 8'h04}, '{4'h1, 16'h09C5, 8'h00}, '{4'h1, 16'h1D4C, 8'h04}, '{4'h1, 16'h1D4B, 8'h00},
        '{4'h2, 16'h0383, 8'h08}, '{4'h2, 16'h0384, 8'h00}, '{4'h3, 16'h0095, 8'h10}, '{4'h3, 16'h0096, 8'h00},
        '{4'h4, 16'h0095, 8'h00}, '{4'h5, 16'h09C4, 8'h00}, '{4'h6, 16'h01F3, 8'h20}, '{4'h7, 16'h01F3, 8'h00},
        '{4'h8, 16'h0000, 8'h01}, '{4'h9, 16'h0000, 8'h00}, '{4'hA, 16'h01F3, 8'h40}, '{4'hB, 16'h01F3, 8'h00}};
    logic        core_clk = 1'b0, sys_rst = 1'b1, fault_reset = 1'b0;   // clock, reset, fault reset
    logic        modulating, fb_in_use, converter_side_ctrl, sync_req;  // drive state
    logic        weld, can_fail, line_down, estop_pin, safety_pin;      // fault knobs and pins
    logic [15:0] line_freq, line_volt, motor_current, dc_volt, line_rms; // measurements
    logic [1:0]  dc_low_resp;                                           // dc-low response
    logic [3:0]  contactor_cmd = 4'h1, contactor_out;                   // command word and gated coils
    logic        fb_cs, fb_net, can_ok, ilk_ok, stop_modulation, sync_permit, changeover_permit, dc_low_warning;
    logic [7:0]  faults, fault_code;                                    // latched faults and number
    int          errors = 0, checks_done = 0;                           // verdict counters
    always #25 core_clk = ~core_clk;
    lsp_far_side lsp_far_side_inst (.core_clk(core_clk), .contactor_out(contactor_out), .weld(weld),
        .can_fail(can_fail), .line_down(line_down), .fb_converter_side_closed(fb_cs), .fb_net_closed(fb_net),
        .can_link_ok(can_ok), .interlock_ok_pin(ilk_ok));
    lsp_monitor #(.NCONT(4)) lsp_monitor_inst (.core_clk(core_clk), .sys_rst(sys_rst), .modulating(modulating),
        .fb_in_use(fb_in_use), .fb_converter_side_closed(fb_cs), .fb_net_closed(fb_net), .can_link_ok(can_ok),
        .line_freq(line_freq), .line_volt(line_volt), .motor_nom_volt(16'h03E8), .motor_current(motor_current),
        .motor_nom_current(16'h03E8), .converter_side_ctrl(converter_side_ctrl), .dc_volt(dc_volt),
        .dc_low_limit(16'h01F4), .dc_low_resp(dc_low_resp), .line_rms(line_rms), .line_rms_limit(16'h01F4),
        .interlock_ok_pin(ilk_ok), .estop_pin(estop_pin), .safety_pin(safety_pin),
        .contactor_cmd(contactor_cmd), .sync_req(sync_req), .fault_reset(fault_reset),
        .contactor_out(contactor_out), .stop_modulation(stop_modulation), .sync_permit(sync_permit),
        .changeover_permit(changeover_permit), .faults(faults), .dc_low_warning(dc_low_warning),
        .fault_code(fault_code));
    // healthy line, sync requested, converter in control, no fault knob set
    task automatic dflt();
        {modulating, fb_in_use, converter_side_ctrl, sync_req, weld, can_fail, line_down, estop_pin,
            safety_pin} <= 9'h0E0;
        {line_freq, line_volt, motor_current, dc_volt, line_rms} <= {16'h1388, 16'h03E8, 16'h01F4, 16'h0320,
            16'h0320};
        dc_low_resp <= LSP_RESP_FAULT;
    endtask
    // wait whole cycles, then step past the edge so outputs have settled
    task automatic wt(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // lowest latched fault gives the reported number
    function automatic logic [7:0] code_of(logic [7:0] f);
        for (int b = 0; b < 8; b++)
            if (f[b]) return LSP_CODE_BOTH + 8'(b);
        return LSP_CODE_NONE;
    endfunction
    // reset needs a zero contactor word, so the word is dropped while reset is held
    task automatic clr();
        @(posedge core_clk);
        dflt();
        contactor_cmd <= 4'h0;
        fault_reset   <= 1'b1;
        wt(3);
        @(posedge core_clk);
        fault_reset   <= 1'b0;
        contactor_cmd <= 4'h1;
        wt(1);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        test_done();
    end
    initial begin
        dflt();
        wt(12);
        chk("faults in reset", 8'h00, faults);
        chk("contactor_out in reset", 8'h00, {4'h0, contactor_out});
        @(posedge core_clk) sys_rst <= 1'b0;
        wt(8);
        $display("reset test done");
        // one row: disturb the inputs its kind selects, compare, then restore and reset
        for (int i = 0; i < NROW; i++) begin
            @(posedge core_clk);
            case (ROWS[i].kind)
                4'h1: line_freq <= ROWS[i].val;
                4'h2: line_volt <= ROWS[i].val;
                4'h3: motor_current <= ROWS[i].val;
                4'h4: {converter_side_ctrl, motor_current} <= {1'b0, ROWS[i].val};
                4'h5: {sync_req, line_freq} <= {1'b0, ROWS[i].val};
                4'h6: dc_volt <= ROWS[i].val;
                4'h7: {dc_low_resp, dc_volt} <= {LSP_RESP_NONE, ROWS[i].val};
                4'h8: {modulating, weld} <= 2'b11;
                4'h9: {modulating, weld, fb_in_use} <= 3'b110;
                4'hA: line_rms <= ROWS[i].val;
                4'hB: {dc_low_resp, dc_volt} <= {2'b11, ROWS[i].val};
                default: ;
            endcase
            wt(4);
            chk("faults", ROWS[i].ef, faults);
            chk("fault_code", code_of(ROWS[i].ef), fault_code);
            chk("contactor_out", |ROWS[i].ef[6:5] ? 8'h00 : 8'h01, {4'h0, contactor_out});
            chk("sync_permit", {7'h0, ROWS[i].ef == 8'h00 && ROWS[i].kind != 4'h5}, {7'h0, sync_permit});
            chk("changeover_permit", {7'h0, ROWS[i].ef == 8'h00 && ROWS[i].kind != 4'h5},
                {7'h0, changeover_permit});
            chk("stop_modulation", {7'h0, ROWS[i].ef[0]}, {7'h0, stop_modulation});
            clr();
            $display("row %0d done", i);
        end
        // dc-low, line-low and interlock faults refuse a reset while the word is nonzero
        for (int k = 0; k < 3; k++) begin
            @(posedge core_clk);
            {dc_volt, line_rms, line_down} <= {k == 0 ? 16'h01F3 : 16'h0320, k == 1 ? 16'h01F3 : 16'h0320, k == 2};
            wt(8);
            chk("fault latched", 8'h20 << k, faults);
            @(posedge core_clk);
            dflt();
            fault_reset <= 1'b1;
            wt(8);
            chk("reset refused", 8'h20 << k, faults);
            clr();
            chk("reset taken", 8'h00, faults);
            $display("refusal test %0d done", k);
        end
        // warning response opens contactors and clears by itself
        @(posedge core_clk) {dc_low_resp, dc_volt} <= {LSP_RESP_WARN, 16'h01F3};
        wt(3);
        chk("dc_low_warning", 8'h01, {7'h0, dc_low_warning});
        chk("contactor_out warn", 8'h00, {4'h0, contactor_out});
        @(posedge core_clk) dc_volt <= 16'h0320;
        wt(3);
        chk("dc_low_warning clear", 8'h00, {7'h0, dc_low_warning});
        $display("warning test done");
        // stop and safety pins each force the coils open while active
        for (int j = 0; j < 2; j++) begin
            @(posedge core_clk) {estop_pin, safety_pin} <= j ? 2'b01 : 2'b10;
            wt(8);
            chk("contactor_out stop", 8'h00, {4'h0, contactor_out});
            @(posedge core_clk) {estop_pin, safety_pin} <= 2'b00;
            wt(8);
            chk("contactor_out free", 8'h01, {4'h0, contactor_out});
        end
        $display("stop pin test done");
        // can loss survives a fault reset and clears only on a second sys_rst
        @(posedge core_clk) can_fail <= 1'b1;
        wt(3);
        chk("can fault", 8'h02, faults);
        chk("contactor_out can", 8'h00, {4'h0, contactor_out});
        clr();
        chk("can kept", 8'h02, faults);
        @(posedge core_clk) sys_rst <= 1'b1;
        wt(2);
        @(posedge core_clk) sys_rst <= 1'b0;
        wt(2);
        chk("can after sys_rst", 8'h00, faults);
        $display("can test done");
        test_done();
    end
endmodule // line_sync_protection_monitor_test
`default_nettype wire
